// File: rtl/temperature_monitor_sequencer.v
/*
 * background monitoring sequencer for one local and two remote diode
 * sensors. steps a secondary converter over the enabled sensors,
 * times each phase, captures results into per-sensor data registers
 * and restarts the cycle itself.
 * also holds the signed ideality trim and the effective ideality
 * that the remote calculation uses.
 * assumes conv_done/conv_result and host_xfer_busy come from logic on
 * clk; enable and trim bits are configuration levels on clk.
 * assumes the converter gives at most one result per started phase,
 * and that it delivers that result inside the phase window.
 * assumes host_xfer_busy stays high for the whole of any transfer
 * between a data register and the host shift register.
 */
`timescale 1ns/100ps
`include "temp_monitor_consts.vh"

module temperature_monitor_sequencer #(
    parameter LOCAL_CYCLES = (`LOCAL_PHASE_US / 1000) * (`CLK_HZ / 1000),
    parameter REMOTE_CYCLES = (`REMOTE_PHASE_US / 1000) * (`CLK_HZ / 1000),
    parameter REMOTE_RC_CYCLES = (`REMOTE_RC_PHASE_US / 1000) * (`CLK_HZ / 1000),
    parameter DUAL_CYCLES = ((`TWO_REMOTE_US - 2 * `REMOTE_PHASE_US) / 1000 + 0) * 0 + 1,
    parameter CNT_W = 23
) (
    input wire clk, // 25 MHz system clock
    input wire resetn, // synchronous reset, active low
    input wire ce, // clock enable, freezes all state when low
    input wire local_sensor_enable, // local sensor enable
    input wire remote_one_enable, // remote sensor one enable
    input wire remote_two_enable, // remote sensor two enable
    input wire series_resistance_cancel_on, // remote series-resistance cancel
    input wire trim_write, // strobe: load ideality trim
    input wire [`TRIM_W-1:0] trim_data, // signed trim code from host
    input wire host_xfer_busy, // data register to shift register busy
    input wire conv_done, // converter result valid pulse
    input wire [`TEMP_W-1:0] conv_result, // processed twos complement result
    output wire conv_start, // pulse: start conversion of conv_sel
    output reg [1:0] conv_sel, // sensor being converted
    output reg conv_cancel, // cancellation applied to this conversion
    output reg [`TRIM_W-1:0] ideality_trim, // current trim code
    output reg [31:0] eta_eff_q16, // effective ideality, 16 fraction bits
    output reg [`TEMP_W-1:0] local_sensor_data, // local sensor result
    output reg [`TEMP_W-1:0] remote_sensor_one_data, // remote one result
    output reg [`TEMP_W-1:0] remote_sensor_two_data, // remote two result
    output wire monitor_busy, // a monitoring cycle is running
    output reg cycle_done // pulse: a cycle finished
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_START = 4'h2;
    localparam [3:0] ST_WAIT = 4'h4;
    localparam [3:0] ST_NEXT = 4'h8;

    // one phase per enabled sensor:
    //   IDLE  waits for any enable, picks the first enabled sensor
    //   START pulses conv_start, loads the phase timer
    //   WAIT  counts the phase down, takes at most one result
    //   NEXT  moves to the next enabled sensor or ends the cycle
    // the cycle time is the sum of the phase counts plus a START and a NEXT
    // edge per phase and one IDLE edge, so the table of
    // cycle lengths follows from the three phase counts alone

    reg [3:0] state;
    reg [CNT_W-1:0] phase_cnt;
    reg [2:0] pend_valid;
    reg [`TEMP_W-1:0] pend_data [0:2];
    reg got_result;
    wire [2:0] enables;
    wire new_result; // a result counted in this cycle
    wire [2:0] slot_hit; // that result belongs to this sensor slot
    wire [31:0] eta_num; // ideality numerator, 16 fraction bits
    wire [31:0] eta_den; // 300 minus the signed trim
    integer i;
    genvar k;

    assign enables = {remote_two_enable, remote_one_enable, local_sensor_enable};

    // first enabled sensor at or after a start index, 2'h3 when none
    function [1:0] pick_sensor;
        input [2:0] en;
        input [1:0] from;
        begin
            pick_sensor = 2'h3;
            if (from <= `IDX_REM2 && en[2])
                pick_sensor = `IDX_REM2;
            if (from <= `IDX_REM1 && en[1])
                pick_sensor = `IDX_REM1;
            if (from == `IDX_LOCAL && en[0])
                pick_sensor = `IDX_LOCAL;
        end
    endfunction

    // phase length for one sensor under the cancel setting
    function [CNT_W-1:0] phase_len;
        input [1:0] sel;
        input rc;
        begin
            if (sel == `IDX_LOCAL)
                phase_len = LOCAL_CYCLES[CNT_W-1:0];
            else if (rc)
                phase_len = REMOTE_RC_CYCLES[CNT_W-1:0];
            else
                phase_len = REMOTE_CYCLES[CNT_W-1:0];
        end
    endfunction

    // sensor index code of a slot number
    function [1:0] slot_code;
        input integer n;
        begin
            slot_code = n[1:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign conv_start = (state == ST_START);
    assign monitor_busy = (state != ST_IDLE);

    // walks enabled sensors, times each phase, then wraps around
    always @(posedge clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            conv_sel <= `IDX_LOCAL;
            conv_cancel <= 1'b0;
            phase_cnt <= {CNT_W{1'b0}};
            got_result <= 1'b0;
            cycle_done <= 1'b0;
        end else if (ce) begin
            cycle_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // idle while no sensor is enabled
                    if (pick_sensor(enables, `IDX_LOCAL) != 2'h3) begin
                        conv_sel <= pick_sensor(enables, `IDX_LOCAL);
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    // cancellation only on remote channels with bit set
                    conv_cancel <= series_resistance_cancel_on && (conv_sel != `IDX_LOCAL);
                    phase_cnt <= phase_len(conv_sel, series_resistance_cancel_on);
                    got_result <= 1'b0;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done)
                        got_result <= 1'b1;
                    if (phase_cnt <= {{(CNT_W-1){1'b0}}, 1'b1})
                        state <= ST_NEXT;
                    else
                        phase_cnt <= phase_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                end
                ST_NEXT: begin
                    // advance to next enabled sensor, skip disabled
                    if (conv_sel != `IDX_REM2 &&
                        pick_sensor(enables, conv_sel + 2'h1) != 2'h3) begin
                        conv_sel <= pick_sensor(enables, conv_sel + 2'h1);
                        state <= ST_START;
                    end else begin
                        // cycle over: restart without host action
                        cycle_done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // result capture and data registers
    // ----------------------------------------------------------------
    // a result counts only inside the timed window of its own phase and
    // only once per phase; a stray pulse would land in the wrong register
    assign new_result = (state == ST_WAIT) && conv_done && !got_result;

    // per-slot decode of the sensor that the result belongs to
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_slot
            assign slot_hit[k] = new_result && (conv_sel == slot_code(k));
        end
    endgenerate

    // with no host transfer a fresh result goes straight to its register;
    // during a transfer it parks in its slot (newest wins) and moves over
    // on the first free edge, so a read never sees a half-updated value
    always @(posedge clk) begin
        if (!resetn) begin
            pend_valid <= 3'h0;
            for (i = 0; i < 3; i = i + 1)
                pend_data[i] <= `TEMP_RESET;
            local_sensor_data <= `TEMP_RESET;
            remote_sensor_one_data <= `TEMP_RESET;
            remote_sensor_two_data <= `TEMP_RESET;
        end else if (ce) begin
            if (!host_xfer_busy) begin
                // commit parked results first
                if (pend_valid[`IDX_LOCAL])
                    local_sensor_data <= pend_data[`IDX_LOCAL];
                if (pend_valid[`IDX_REM1])
                    remote_sensor_one_data <= pend_data[`IDX_REM1];
                if (pend_valid[`IDX_REM2])
                    remote_sensor_two_data <= pend_data[`IDX_REM2];
                // a fresh result is newer than a parked one and wins
                // twelve-bit twos complement at 0.125 degree
                if (slot_hit[`IDX_LOCAL])
                    local_sensor_data <= conv_result;
                if (slot_hit[`IDX_REM1])
                    remote_sensor_one_data <= conv_result;
                if (slot_hit[`IDX_REM2])
                    remote_sensor_two_data <= conv_result;
                pend_valid <= 3'h0;
            end else if (new_result) begin
                // transfer running: registers hold, result parks
                pend_data[conv_sel] <= conv_result;
                pend_valid[conv_sel] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // ideality trim
    // ----------------------------------------------------------------
    // signed byte trim, zero at reset
    always @(posedge clk) begin
        if (!resetn)
            ideality_trim <= `TRIM_RESET;
        else if (ce && trim_write)
            ideality_trim <= trim_data;
    end

    // numerator and denominator of the ideality correction; the trim is
    // sign-extended so a negative code widens the denominator. the
    // denominator spans 173 to 428, so it can never reach zero
    assign eta_num = `ETA_NOM_Q16 * {22'h0, `ETA_DEN_BASE};
    assign eta_den = {22'h0, `ETA_DEN_BASE} - {{24{ideality_trim[7]}}, ideality_trim};

    // eta = 1.008*300/(300-trim) in 16 fraction bits
    // registered one edge after the trim so the divider has a full cycle
    always @(posedge clk) begin
        if (!resetn)
            eta_eff_q16 <= `ETA_NOM_Q16;
        else if (ce)
            eta_eff_q16 <= eta_num / eta_den;
    end

endmodule // temperature_monitor_sequencer

// File: rtl/temp_monitor_consts.vh
/*
 * constants for the temperature monitor sequencer: sensor indices,
 * data format, trim figures and monitoring phase times.
 * assumes a 25 MHz system clock; included by bare name.
 */
`ifndef TEMP_MONITOR_CONSTS_VH
`define TEMP_MONITOR_CONSTS_VH

// ----------------------------------------------------------------
// clock and phase timing
// ----------------------------------------------------------------
`define CLK_HZ 25000000
// local phase 15 ms, remote phase 44 ms with cancel off, 93 ms with it on
`define LOCAL_PHASE_US 15000
`define REMOTE_PHASE_US 44000
`define REMOTE_RC_PHASE_US 93000
// dual-remote cycle is exactly two single phases
`define TWO_REMOTE_US 88000
`define TWO_REMOTE_RC_US 186000

// ----------------------------------------------------------------
// data format
// ----------------------------------------------------------------
`define TEMP_W 12
`define TRIM_W 8
`define TRIM_RESET 8'h00
`define TEMP_RESET 12'h000
// ideality scaled by 2^16: 1.008 * 65536 = 66060.288
`define ETA_NOM_Q16 32'h0001_020C
`define ETA_DEN_BASE 10'h12C

// ----------------------------------------------------------------
// sensor indices
// ----------------------------------------------------------------
`define IDX_LOCAL 2'h0
`define IDX_REM1 2'h1
`define IDX_REM2 2'h2

`endif

// File: dv/conv_model.sv
/* converter stand-in: answers conv_start with conv_done lag+1 edges after sampling it.
   assumes it shares clk with the sequencer. */
`timescale 1ns/100ps
module conv_model (
    input wire clk, // system clock
    input wire conv_start, // start pulse
    input wire [1:0] conv_sel, // sensor index
    input wire [3:0] lag, // answer delay
    input wire [35:0] values, // remote two, remote one, local codes
    output reg conv_done = 1'b0, // result valid pulse
    output reg [11:0] conv_result = 12'hA5A // toggles while not valid
);
    reg [4:0] cnt = 5'h00; // bit 4 marks a running conversion
    // count down the lag, then show the selected code for one cycle
    always @(posedge clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (conv_start) begin
            cnt <= {1'b1, lag};
        end else if (cnt == 5'h10) begin
            cnt <= 5'h00;
            conv_done <= 1'b1;
            conv_result <= values[conv_sel * 12 +: 12];
        end else if (cnt[4]) begin
            cnt <= cnt - 5'h01;
        end
    end
endmodule // conv_model

// File: dv/temp_monitor_chk.sv
/* port assertions for the monitor sequencer.
   assumes ce is held high by the bench. */
`timescale 1ns/100ps
module temp_monitor_chk (
    input wire clk, resetn, // clock, reset
    input wire local_sensor_enable, remote_one_enable, remote_two_enable, // enables
    input wire series_resistance_cancel_on, trim_write, host_xfer_busy, // controls
    input wire [7:0] trim_data, ideality_trim, // trim in and held
    input wire conv_done, conv_start, conv_cancel, monitor_busy, cycle_done, // status
    input wire [1:0] conv_sel, // sensor index
    input wire [11:0] conv_result, local_sensor_data, // code, local data
    input wire [11:0] remote_sensor_one_data, remote_sensor_two_data, // remote data
    input wire [31:0] eta_eff_q16 // effective ideality
);
    wire any_on = local_sensor_enable | remote_one_enable | remote_two_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_skip_local: assert property (conv_start && conv_sel == 2'h0 |->
        local_sensor_enable || $past(local_sensor_enable)) else $error("local off");
    a_skip_remote: assert property (conv_start && conv_sel == 2'h1 |->
        remote_one_enable || $past(remote_one_enable)) else $error("remote one off");
    a_idle_quiet: assert property (!any_on && !monitor_busy |=> !conv_start)
        else $error("start with no enable");
    a_auto_restart: assert property (cycle_done && any_on ##1 any_on |->
        ##[0:3] conv_start) else $error("no restart");
    a_data_frozen: assert property (host_xfer_busy |=> $stable({local_sensor_data,
        remote_sensor_one_data, remote_sensor_two_data})) else $error("data moved");
    a_trim_load: assert property (trim_write |=> ideality_trim == $past(trim_data))
        else $error("trim not loaded");
    a_trim_nominal: assert property (trim_write && trim_data == 8'h00 |->
        ##[1:3] eta_eff_q16 == 32'h0001020C) else $error("nominal ideality wrong");
    a_cancel_match: assert property (conv_start |=> conv_cancel ==
        ($past(conv_sel) != 2'h0 && $past(series_resistance_cancel_on))) else $error("cancel");
    a_local_commit: assert property (conv_done && conv_sel == 2'h0 && !host_xfer_busy |->
        ##1 local_sensor_data == $past(conv_result)) else $error("local not stored");
endmodule // temp_monitor_chk
bind temperature_monitor_sequencer temp_monitor_chk temp_monitor_chk_i (.clk, .resetn,
    .local_sensor_enable, .remote_one_enable, .remote_two_enable,
    .series_resistance_cancel_on, .trim_write, .host_xfer_busy, .trim_data, .ideality_trim,
    .conv_done, .conv_start, .conv_cancel, .monitor_busy, .cycle_done, .conv_sel,
    .conv_result, .local_sensor_data, .remote_sensor_one_data, .remote_sensor_two_data,
    .eta_eff_q16);

// File: dv/test_temperature_monitor_sequencer.sv
/* self-checking bench for the monitor sequencer with a converter stand-in.
   assumes short phase counts so whole cycles fit a short run. */
`timescale 1ns/100ps
module test_temperature_monitor_sequencer;
    reg clk = 1'b0, resetn = 1'b0, ce = 1'b1, host_xfer_busy = 1'b0, trim_write = 1'b0;
    reg [2:0] en = 3'h0; // remote two, remote one, local
    reg rc = 1'b0;
    reg [7:0] trim_data = 8'h00;
    reg [3:0] lag = 4'h2;
    reg [35:0] values = 36'h0;
    reg [79:0] rows [0:2];
    integer num_errors = 0, comparisons = 0, i;
    wire conv_done, conv_start, conv_cancel, monitor_busy, cycle_done;
    wire [1:0] conv_sel;
    wire [11:0] conv_result, local_sensor_data, remote_sensor_one_data, remote_sensor_two_data;
    wire [7:0] ideality_trim;
    wire [31:0] eta_eff_q16;
    temperature_monitor_sequencer #(.LOCAL_CYCLES(20), .REMOTE_CYCLES(40),
        .REMOTE_RC_CYCLES(80)) temperature_monitor_sequencer_i (.clk, .resetn, .ce,
        .local_sensor_enable(en[0]), .remote_one_enable(en[1]), .remote_two_enable(en[2]),
        .series_resistance_cancel_on(rc), .trim_write, .trim_data, .host_xfer_busy,
        .conv_done, .conv_result, .conv_start, .conv_sel, .conv_cancel, .ideality_trim,
        .eta_eff_q16, .local_sensor_data, .remote_sensor_one_data, .remote_sensor_two_data,
        .monitor_busy, .cycle_done);
    conv_model conv_model_i (.clk, .conv_start, .conv_sel, .lag, .values, .conv_done,
        .conv_result);
    // free-running 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task check(input [47:0] got, input [47:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // bounded wait for the end of a monitoring cycle
    task wait_done;
        integer n;
        begin
            n = 0;
            while (cycle_done !== 1'b1 && n < 1000) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n == 1000) num_errors = num_errors + 1;
            @(negedge clk);
        end
    endtask
    // watchdog well beyond the expected run
    initial begin
        #800000;
        num_errors = num_errors + 1;
        conclude;
    end
    initial begin
        rows[0] = 80'hE2_4B0F380C8_4B0F380C8;
        rows[1] = 80'hBF_CE0E70320_CE0F38320;
        rows[2] = 80'h42_4B03200C8_CE0320320;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        check({ideality_trim, eta_eff_q16}, 40'h000001020C);
        $display("reset done");
        // rows: enables, cancel and lag, then codes and the stored result
        for (i = 0; i < 3; i = i + 1) begin
            {en, rc, lag} = rows[i][79:72];
            wait_done;
            values = rows[i][71:36];
            wait_done;
            check({remote_sensor_two_data, remote_sensor_one_data, local_sensor_data},
                rows[i][35:0]);
        end
        $display("table done");
        for (i = 0; i < 4; i = i + 1) begin
            trim_data = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : (i == 2) ? 8'hFF : 8'h00;
            trim_write = 1'b1;
            @(negedge clk);
            trim_write = 1'b0;
            @(negedge clk);
            check(ideality_trim, trim_data);
        end
        repeat (3) @(negedge clk);
        check(eta_eff_q16, 32'h0001020C);
        $display("trim done");
        en = 3'h1;
        values = 36'h4B03200C8;
        wait_done;
        wait_done;
        host_xfer_busy = 1'b1;
        values = 36'h4B0320800;
        wait_done;
        check(local_sensor_data, 12'h0C8);
        host_xfer_busy = 1'b0;
        repeat (2) @(negedge clk);
        check(local_sensor_data, 12'h800);
        $display("freeze done");
        en = 3'h0;
        repeat (300) @(negedge clk);
        values = 36'h7FF7FF7FF;
        repeat (300) @(negedge clk);
        check({monitor_busy, remote_sensor_two_data, remote_sensor_one_data,
            local_sensor_data}, {1'b0, 36'hCE0320800});
        $display("idle done");
        conclude;
    end
endmodule // test_temperature_monitor_sequencer
